// [hdl/pcq_defs.vh]
// constants for the pulse counter / quadrature decoder block
// assumes a single 125 MHz clock and an ahb-lite master that uses whole-word transfers
// Summary of operation
// - every pulse channel adds its detected edges into its own 24-bit counter.
// - at each scan tick the count is captured, then the counter restarts from zero.
// - counting past 24 bits wraps and marks that scan's captured value invalid.
// - rising and falling input changes are both recognised as countable events.
// - switch-closure inputs are debounced so one closure gives one count.
// - debounce makes switch-closure rate limit lower than square-wave mode.
// - per channel output: counts per scan, frequency, or running average of frequency.
// - resolution is one pulse per scan, so frequency resolution is one over interval.
// - two input pins can be paired as encoder phases a and b.
// - net signed count goes up when a leads, down when b leads.
// - decoder also reports direction and separate a-leads and b-leads tallies.
// - single-edge mode: up on a rising when a leads, down on a falling.
// - double-edge mode: count on both edges of a, sign by leading phase.
// - quadruple-edge mode: count every edge of both phases, sign by leading phase.
`ifndef PCQ_DEFS_VH
`define PCQ_DEFS_VH
`define PCQ_CNT_W 24
`define PCQ_CLK_MHZ 125
`define PCQ_DEB_US 1000
`define PCQ_SCAN_MS 1000
`define PCQ_ADDR_W 8
`define PCQ_REG_CTRL 8'h00
`define PCQ_REG_SCAN 8'h04
`define PCQ_REG_EDGE 8'h08
`define PCQ_REG_OSEL 8'h0C
`define PCQ_REG_SCALE 8'h10
`define PCQ_REG_ISTAT 8'h14
`define PCQ_REG_IMASK 8'h18
`define PCQ_REG_QNET 8'h1C
`define PCQ_REG_QUP 8'h20
`define PCQ_REG_QDN 8'h24
`define PCQ_REG_QDIR 8'h28
`define PCQ_REG_OVF 8'h2C
`define PCQ_REG_RES0 8'h40
`define PCQ_SCALE_RST 32'h0001_0000
`define PCQ_SCALE_SH 16
`define PCQ_QM_X1 2'h0
`define PCQ_QM_X2 2'h1
`define PCQ_QM_X4 2'h2
`define PCQ_OS_CNT 2'h0
`define PCQ_OS_FREQ 2'h1
`define PCQ_OS_AVG 2'h2
`define PCQ_ED_RISE 2'h0
`define PCQ_ED_FALL 2'h1
`define PCQ_ED_BOTH 2'h2
`define PCQ_AVG_SH 2
`define PCQ_HTRANS_NSEQ 2'h2
`endif

// [hdl/pcq_top.v]
// pulse counters, switch debouncers and a quadrature decoder behind an ahb-lite slave
// assumes async pins on single_ended_inputs and encoder inputs; one clock, async active-low reset
`include "pcq_defs.vh"
module pcq_top #(
  parameter NCH = 4,
  parameter DEB_CYC = `PCQ_DEB_US * `PCQ_CLK_MHZ,
  parameter SCAN_CYC = `PCQ_SCAN_MS * 1000 * `PCQ_CLK_MHZ
) (
  input wire sys_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [NCH-1:0] single_ended_inputs,
  input wire encoder_pair_a,
  input wire encoder_pair_b,
  input wire encoder_pair_a_alt,
  input wire encoder_pair_b_alt,
  output wire irq,
  output wire scan_tick
);
  localparam CW = `PCQ_CNT_W;
  localparam NIRQ = NCH + 1;

  // synchronisers: stage one feeds only stage two
  reg [NCH+3:0] sync1_ff;
  reg [NCH+3:0] sync2_ff;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= {(NCH+4){1'b0}};
      sync2_ff <= {(NCH+4){1'b0}};
    end else begin
      sync1_ff <= {encoder_pair_b_alt, encoder_pair_a_alt, encoder_pair_b, encoder_pair_a,
                   single_ended_inputs};
      sync2_ff <= sync1_ff;
    end
  end

  // pins may idle high while the synchronisers reset low; no edge counts until they fill
  reg [2:0] prime_ff;
  wire primed = prime_ff[2];
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prime_ff <= 3'h0;
    end else begin
      prime_ff <= {prime_ff[1:0], 1'b1};
    end
  end

  // software-visible control
  reg [31:0] ctrl_ff;
  reg [31:0] scan_len_ff;
  reg [31:0] edge_cfg_ff;
  reg [31:0] osel_ff;
  reg [31:0] scale_ff;
  reg [NIRQ-1:0] istat_ff;
  reg [NIRQ-1:0] imask_ff;

  // scan interval timer; interval sets frequency resolution
  reg [31:0] scan_cnt_ff;
  reg tick_ff;
  wire tick_now = (scan_cnt_ff >= scan_len_ff - 32'h0000_0001);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scan_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      scan_cnt_ff <= tick_now ? 32'h0000_0000 : scan_cnt_ff + 32'h0000_0001;
      tick_ff <= tick_now;
    end
  end
  assign scan_tick = tick_ff;

  // per-channel pulse path
  wire [CW-1:0] cap_w [0:NCH-1];
  wire [CW-1:0] freq_w [0:NCH-1];
  wire [CW-1:0] avg_w [0:NCH-1];
  wire [NCH-1:0] ovf_cap_w;
  wire [NCH-1:0] ovf_ev_w;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg deb_ff;
      reg [31:0] deb_cnt_ff;
      reg prev_ff;
      reg [CW-1:0] cnt_ff;
      reg [CW-1:0] cap_ff;
      reg [CW-1:0] avg_ff;
      reg ovf_ff;
      reg ovf_cap_ff;
      wire [1:0] esel = edge_cfg_ff[4*g+1:4*g];
      wire sw_mode = edge_cfg_ff[4*g+2];
      wire raw = sync2_ff[g];
      // switch mode accepts a level only after it has been stable a full debounce window;
      // this caps the closure rate well below the square-wave rate
      wire deb_done = (deb_cnt_ff >= DEB_CYC - 1);
      wire lvl = sw_mode ? deb_ff : raw;
      wire rise = lvl & ~prev_ff;
      wire fall = ~lvl & prev_ff;
      // both level changes are recognised; config picks which ones count
      wire hit = primed & ((esel == `PCQ_ED_RISE) ? rise :
                 (esel == `PCQ_ED_FALL) ? fall :
                 (esel == `PCQ_ED_BOTH) ? (rise | fall) : 1'b0);
      // an edge in the capture cycle opens the next scan, so it cannot overflow this one
      wire wrap = hit & ~tick_now & (&cnt_ff);
      wire [CW+31:0] prod = cnt_ff * scale_ff;
      wire [CW-1:0] fnew = prod[CW+`PCQ_SCALE_SH-1:`PCQ_SCALE_SH];
      wire [CW+1:0] avg_sum = {2'b00, avg_ff} - {{(`PCQ_AVG_SH){1'b0}},
                              avg_ff[CW-1:`PCQ_AVG_SH]} + {{(`PCQ_AVG_SH){1'b0}},
                              fnew[CW-1:`PCQ_AVG_SH]};
      always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          deb_ff <= 1'b0;
          deb_cnt_ff <= 32'h0000_0000;
          prev_ff <= 1'b0;
          cnt_ff <= {CW{1'b0}};
          cap_ff <= {CW{1'b0}};
          avg_ff <= {CW{1'b0}};
          ovf_ff <= 1'b0;
          ovf_cap_ff <= 1'b0;
        end else begin
          if (raw == deb_ff) begin
            deb_cnt_ff <= 32'h0000_0000;
          end else if (deb_done) begin
            deb_ff <= raw;
            deb_cnt_ff <= 32'h0000_0000;
          end else begin
            deb_cnt_ff <= deb_cnt_ff + 32'h0000_0001;
          end
          prev_ff <= lvl;
          if (tick_now) begin
            // capture then restart; an edge in this cycle opens the next interval
            cap_ff <= cnt_ff;
            cnt_ff <= hit ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
            avg_ff <= avg_sum[CW-1:0];
            ovf_cap_ff <= ovf_ff;
            ovf_ff <= 1'b0;
          end else if (hit) begin
            cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
            if (wrap) begin
              ovf_ff <= 1'b1;
            end
          end
        end
      end
      wire [CW+31:0] cprod = cap_ff * scale_ff;
      assign cap_w[g] = cap_ff;
      assign freq_w[g] = cprod[CW+`PCQ_SCALE_SH-1:`PCQ_SCALE_SH];
      assign avg_w[g] = avg_ff;
      assign ovf_cap_w[g] = ovf_cap_ff;
      assign ovf_ev_w[g] = wrap;
    end
  endgenerate

  // quadrature decoder
  wire q_alt = ctrl_ff[2];
  wire q_en = ctrl_ff[3];
  wire [1:0] qmode = ctrl_ff[1:0];
  wire qa = q_alt ? sync2_ff[NCH+2] : sync2_ff[NCH];
  wire qb = q_alt ? sync2_ff[NCH+3] : sync2_ff[NCH+1];
  reg [1:0] qprev_ff;
  reg [CW-1:0] qnet_ff;
  reg [CW-1:0] qup_ff;
  reg [CW-1:0] qdn_ff;
  reg [CW-1:0] qup_cap_ff;
  reg [CW-1:0] qdn_cap_ff;
  reg qdir_ff;
  reg [1:0] nxt_step;
  always @* begin
    // nxt_step[0]: a-leads step, nxt_step[1]: b-leads step; jumps of two bits give none
    nxt_step = 2'b00;
    case ({qprev_ff, qa, qb})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: nxt_step = 2'b01;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: nxt_step = 2'b10;
      default: nxt_step = 2'b00;
    endcase
  end
  wire a_moved = qprev_ff[1] ^ qa;
  wire a_rise = ~qprev_ff[1] & qa;
  wire a_fall = qprev_ff[1] & ~qa;
  reg q_up;
  reg q_dn;
  always @* begin
    q_up = 1'b0;
    q_dn = 1'b0;
    case (qmode)
      `PCQ_QM_X1: begin
        q_up = nxt_step[0] & a_rise;
        q_dn = nxt_step[1] & a_fall;
      end
      `PCQ_QM_X2: begin
        q_up = nxt_step[0] & a_moved;
        q_dn = nxt_step[1] & a_moved;
      end
      `PCQ_QM_X4: begin
        q_up = nxt_step[0];
        q_dn = nxt_step[1];
      end
      default: begin
        q_up = 1'b0;
        q_dn = 1'b0;
      end
    endcase
    q_up = q_up & q_en & primed;
    q_dn = q_dn & q_en & primed;
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qprev_ff <= 2'b00;
      qnet_ff <= {CW{1'b0}};
      qup_ff <= {CW{1'b0}};
      qdn_ff <= {CW{1'b0}};
      qup_cap_ff <= {CW{1'b0}};
      qdn_cap_ff <= {CW{1'b0}};
      qdir_ff <= 1'b0;
    end else begin
      qprev_ff <= {qa, qb};
      if (q_up) begin
        qnet_ff <= qnet_ff + {{(CW-1){1'b0}}, 1'b1};
        qdir_ff <= 1'b0;
      end else if (q_dn) begin
        qnet_ff <= qnet_ff - {{(CW-1){1'b0}}, 1'b1};
        qdir_ff <= 1'b1;
      end
      // direction tallies follow the same capture-and-clear as pulse counters
      if (tick_now) begin
        qup_cap_ff <= qup_ff;
        qdn_cap_ff <= qdn_ff;
        qup_ff <= q_up ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
        qdn_ff <= q_dn ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
      end else begin
        qup_ff <= qup_ff + {{(CW-1){1'b0}}, q_up};
        qdn_ff <= qdn_ff + {{(CW-1){1'b0}}, q_dn};
      end
    end
  end

  // ahb-lite slave: zero wait states, read data registered in the address phase
  wire take = hsel & hready & (htrans == `PCQ_HTRANS_NSEQ);
  wire [`PCQ_ADDR_W-1:0] a_w = haddr[`PCQ_ADDR_W-1:0];
  reg wr_pend_ff;
  reg [`PCQ_ADDR_W-1:0] wr_addr_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg irq_ff;
  reg [31:0] nxt_rd;
  reg rd_istat;
  integer i;
  always @* begin
    nxt_rd = 32'h0000_0000;
    rd_istat = 1'b0;
    case (a_w)
      `PCQ_REG_CTRL: nxt_rd = ctrl_ff;
      `PCQ_REG_SCAN: nxt_rd = scan_len_ff;
      `PCQ_REG_EDGE: nxt_rd = edge_cfg_ff;
      `PCQ_REG_OSEL: nxt_rd = osel_ff;
      `PCQ_REG_SCALE: nxt_rd = scale_ff;
      `PCQ_REG_ISTAT: begin
        nxt_rd = {{(32-NIRQ){1'b0}}, istat_ff};
        rd_istat = take & ~hwrite;
      end
      `PCQ_REG_IMASK: nxt_rd = {{(32-NIRQ){1'b0}}, imask_ff};
      `PCQ_REG_QNET: nxt_rd = {{(32-CW){qnet_ff[CW-1]}}, qnet_ff};
      `PCQ_REG_QUP: nxt_rd = {{(32-CW){1'b0}}, qup_cap_ff};
      `PCQ_REG_QDN: nxt_rd = {{(32-CW){1'b0}}, qdn_cap_ff};
      `PCQ_REG_QDIR: nxt_rd = {31'h0000_0000, qdir_ff};
      `PCQ_REG_OVF: nxt_rd = {{(32-NCH){1'b0}}, ovf_cap_w};
      default: nxt_rd = 32'h0000_0000;
    endcase
    for (i = 0; i < NCH; i = i + 1) begin
      if (a_w == `PCQ_REG_RES0 + 4 * i) begin
        case (osel_ff[2*i +: 2])
          `PCQ_OS_FREQ: nxt_rd = {{(32-CW){1'b0}}, freq_w[i]};
          `PCQ_OS_AVG: nxt_rd = {{(32-CW){1'b0}}, avg_w[i]};
          default: nxt_rd = {{(32-CW){1'b0}}, cap_w[i]};
        endcase
      end
    end
  end

  // new events win over the read that clears them
  wire [NIRQ-1:0] ev = {ovf_ev_w, tick_now};
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= {`PCQ_ADDR_W{1'b0}};
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
      irq_ff <= 1'b0;
      ctrl_ff <= 32'h0000_0000;
      scan_len_ff <= SCAN_CYC;
      edge_cfg_ff <= 32'h0000_0000;
      osel_ff <= 32'h0000_0000;
      scale_ff <= `PCQ_SCALE_RST;
      istat_ff <= {NIRQ{1'b0}};
      imask_ff <= {NIRQ{1'b0}};
    end else begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff <= take & hwrite;
      wr_addr_ff <= a_w;
      if (take & ~hwrite) begin
        hrdata_ff <= nxt_rd;
      end
      istat_ff <= (istat_ff & ~{NIRQ{rd_istat}}) | ev;
      irq_ff <= |(((istat_ff & ~{NIRQ{rd_istat}}) | ev) & imask_ff);
      if (wr_pend_ff) begin
        case (wr_addr_ff)
          `PCQ_REG_CTRL: ctrl_ff <= {28'h000_0000, hwdata[3:0]};
          `PCQ_REG_SCAN: scan_len_ff <= (hwdata == 32'h0000_0000) ? 32'h0000_0001 : hwdata;
          `PCQ_REG_EDGE: edge_cfg_ff <= hwdata;
          `PCQ_REG_OSEL: osel_ff <= hwdata;
          `PCQ_REG_SCALE: scale_ff <= hwdata;
          `PCQ_REG_IMASK: imask_ff <= hwdata[NIRQ-1:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign irq = irq_ff;
endmodule

// [tb/pcq_assertions.sv]
// port checker for pcq_top
// assumes the scan interval stays above eight cycles
module pcq_chk #(parameter NCH = 4) (
  input wire sys_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire scan_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire rd = hsel && hready && htrans == 2'h2 && !hwrite;
  wire [7:0] a = haddr[7:0];
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_ready_high: assert property ($past(rstn) |-> hreadyout) else $error("wait state");
  a_tick_gap: assert property (scan_tick |=> !scan_tick [*8])
    else $error("ticks too close");
  a_rdata_hold: assert property (!$past(rd) |-> $stable(hrdata)) else $error("data moved");
  a_unmapped_zero: assert property (rd && a == 8'h30 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_qnet_sign: assert property (rd && a == 8'h1C |=> hrdata[31:24] == {8{hrdata[23]}})
    else $error("net not sign extended");
  a_tally_width: assert property (rd && a[7:3] == 5'h04 |=> hrdata[31:24] == 8'h00)
    else $error("tally too wide");
  a_dir_bit: assert property (rd && a == 8'h28 |=> hrdata[31:1] == 31'h0000_0000)
    else $error("direction too wide");
  a_ovf_width: assert property (rd && a == 8'h2C |=> (hrdata >> NCH) == 32'h0000_0000)
    else $error("overflow too wide");
endmodule

// [tb/pcq_src.sv]
// far side: pulse sensors, a switch contact, two shaft encoders
// assumes tasks are entered just after a rising edge
module pcq_src (
  input wire sys_clk,
  output logic [3:0] pins,
  output logic [1:0] enc,
  output logic [1:0] alt
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  int qh = 0;
  // pull-ups keep idle pins high
  initial begin
    pins = 4'hf;
    enc = 2'h0;
    alt = 2'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      pins <= pins & ~m;
      hold(2);
      pins <= pins | m;
      hold(2);
    end
  endtask
  // bounce shorter than the debounce span, then settle
  task automatic closure(input logic lvl);
    repeat (3) begin
      pins[0] <= lvl;
      hold(1);
      pins[0] <= !lvl;
      hold(1);
    end
    pins[0] <= lvl;
    hold(16);
  endtask
  // ab order 00,10,11,01 is a-leads; the other pair runs backwards as a decoy
  task automatic step(input int dir, input int n);
    repeat (n) begin
      ph = (ph + dir) & 3;
      qh = (qh - dir) & 3;
      enc <= {ph[1] ^ ph[0], ph[1]};
      alt <= {qh[1] ^ qh[0], qh[1]};
      hold(4);
    end
  endtask
  // only legal from 00
  task automatic jump();
    enc <= 2'h3;
    alt <= 2'h3;
    hold(4);
    enc <= 2'h0;
    alt <= 2'h0;
    hold(4);
  endtask
endmodule

// [tb/tb_pulse_counter_quadrature_decoder.sv]
// self-checking bench for pcq_top
// assumes pcq_defs.vh on the include path; pcq_src drives all pins
`include "pcq_defs.vh"
module tb_pulse_counter_quadrature_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_a958;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, scan_tick;
  wire [3:0] pins;
  wire [1:0] enc, alt;
  int err_count = 0;
  int samples_checked = 0;
  always #4 sys_clk = ~sys_clk;
  pcq_top #(.NCH(4), .DEB_CYC(8), .SCAN_CYC(200)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .single_ended_inputs(pins), .encoder_pair_a(enc[1]),
    .encoder_pair_b(enc[0]), .encoder_pair_a_alt(alt[1]), .encoder_pair_b_alt(alt[0]),
    .irq(irq), .scan_tick(scan_tick));
  pcq_src src (.sys_clk(sys_clk), .pins(pins), .enc(enc), .alt(alt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(exp, hrdata);
  endtask
  // irq is registered with status but lags an imask write by one cycle, so allow three edges
  task automatic irqc(input logic exp);
    repeat (3) @(posedge sys_clk);
    chk({31'h0000_0000, exp}, {31'h0000_0000, irq});
  endtask
  task automatic tick();
    do @(posedge sys_clk); while (scan_tick !== 1'b1);
  endtask
  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
  initial begin
    int n, u, d, k, m, sd, net;
    int e[4];
    int km[4];
    km = '{1, 2, 4, 0};
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_00c8);
    rdc(8'h10, 32'h0001_0000);
    rdc(8'h30, 32'h0000_0000);
    $display("reset values done");
    tick();
    xfer(8'h10, 1'b1, 32'h0003_0000);
    xfer(8'h0c, 1'b1, 32'h0000_0009);
    n = 4 * (1 + rnd() % 2);
    src.pulse(4'h3, n);
    tick();
    rdc(8'h40, 3 * n);
    rdc(8'h44, 3 * n / 4);
    $display("output modes done");
    xfer(8'h0c, 1'b1, 32'h0000_0000);
    xfer(8'h10, 1'b1, 32'h0001_0000);
    xfer(8'h08, 1'b1, 32'h0000_3210);
    tick();
    n = 1 + rnd() % 8;
    src.pulse(4'hf, n);
    e = '{n, n, 2 * n, 0};
    tick();
    for (k = 0; k < 4; k++) rdc(8'(8'h40 + 4 * k), e[k]);
    rdc(8'h2C, 32'h0000_0000);
    $display("edge counting done");
    xfer(8'h08, 1'b1, 32'h0000_0004);
    tick();
    repeat (2) begin
      src.closure(1'b0);
      src.closure(1'b1);
    end
    tick();
    rdc(8'h40, 32'h0000_0002);
    $display("debounce done");
    // scan status is sticky from earlier scans
    xfer(8'h18, 1'b1, 32'h0000_0001);
    irqc(1'b1);
    rdc(8'h14, 32'h0000_0001);
    irqc(1'b0);
    tick();
    irqc(1'b1);
    xfer(8'h18, 1'b1, 32'h0000_0000);
    irqc(1'b0);
    rdc(8'h14, 32'h0000_0001);
    $display("interrupt done");
    net = 0;
    for (m = 0; m < 4; m++) begin
      // odd modes use the alternate pair
      xfer(8'h00, 1'b1, 32'(8 + m + 4 * (m & 1)));
      tick();
      sd = (m & 1) ? -1 : 1;
      u = 1 + rnd() % 3;
      d = 1 + rnd() % 3;
      k = km[m];
      src.step(sd, 4 * u);
      src.step(-sd, 4 * d);
      src.jump();
      net += (u - d) * k;
      tick();
      rdc(8'h20, u * k);
      rdc(8'h24, d * k);
      rdc(8'h1C, net);
      if (k > 0) rdc(8'h28, 32'h0000_0001);
    end
    $display("quadrature done");
    conclude();
  end
endmodule
bind pcq_top pcq_chk #(.NCH(NCH)) u_chk (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scan_tick(scan_tick));
